//--- hdl/dic_pkg.sv
`default_nettype none
package dic_pkg;
    localparam int DIC_NCH = 4;
    localparam int DIC_NB = 2;
    localparam int DIC_NP = 8;
    localparam int DIC_PW = 3;
    localparam int DIC_CLK_NS = 100;
    localparam int DIC_TICK_NS = 1000000;
    localparam int DIC_MS_CYC = (DIC_TICK_NS + DIC_CLK_NS - 1) / DIC_CLK_NS;
    localparam int DIC_MSW = 14;
    localparam logic [9:0] DIC_DEB_MAX_MS = 10'h3e8;
    localparam logic [9:0] DIC_DEB_RST = 10'h000;
    localparam logic [5:0] DIC_AC_WIN_MS = 6'h32;
    localparam logic [7:0] DIC_CFG_BASE = 8'h00;
    localparam logic [7:0] DIC_DEB_BASE = 8'h10;
    localparam logic [7:0] DIC_CNT_BASE = 8'h20;
    localparam logic [7:0] DIC_STATE_OFS = 8'h30;
    localparam logic [7:0] DIC_IST_OFS = 8'h34;
    localparam logic [7:0] DIC_ICLR_OFS = 8'h38;
    localparam logic [7:0] DIC_IEN_OFS = 8'h3c;
    localparam logic [31:0] DIC_CFG_RST = 32'h0000_0010;
    localparam logic [2*DIC_NCH-1:0] DIC_IEN_RST = 8'h00;

    typedef enum logic [1:0] {
        DIC_PULSE_MODE = 2'b00,
        DIC_TRANSITION_COUNT_MODE = 2'b01,
        DIC_AC_MODE = 2'b10,
        DIC_TIME_CODE_MODE = 2'b11
    } dic_mode_e;

    typedef struct packed {
        logic [7:0] rsv3;
        logic [7:0] priority_val;
        logic [4:0] rsv2;
        logic [DIC_PW-1:0] port;
        logic [1:0] rsv1;
        logic alarm_on_off;
        logic enable;
        logic event_log_select;
        logic invert;
        dic_mode_e mode;
    } dic_cfg_s;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } dic_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } dic_wb_rsp_s;

    typedef struct packed {
        logic valid;
        logic level;
        logic [7:0] priority_val;
    } dic_log_s;

    typedef struct packed {
        logic [DIC_NP-1:0] sync1;
        logic [DIC_NP-1:0] sync2;
        logic [DIC_MSW-1:0] msdiv;
        logic tick;
        dic_cfg_s [DIC_NCH-1:0] cfg;
        logic [DIC_NCH-1:0][9:0] deb;
        logic [DIC_NCH-1:0][9:0] dbc;
        logic [DIC_NCH-1:0][5:0] actmr;
        logic [DIC_NCH-1:0][15:0] cnt;
        logic [DIC_NCH-1:0] prev;
        logic [DIC_NCH-1:0] state;
        logic [DIC_NCH-1:0] armed;
        logic [DIC_NCH-1:0] trig;
        logic [DIC_NCH-1:0] logv;
        logic [DIC_NB-1:0] irig;
        logic [2*DIC_NCH-1:0] irqst;
        logic [2*DIC_NCH-1:0] irqen;
        logic ack;
        logic [31:0] rdat;
    } dic_state_s;
endpackage
`default_nettype wire

//--- hdl/dic_top.sv
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - pulse mode counts on completed off-on-off
// - transition mode counts every state change
// - AC mode: ON while alternating input seen
// - time-code mode passes level to clock
// - option channels never take time-code mode
// - polarity bit optionally inverts port signal
// - level accepted after stable debounce time
// - log entry only when logging is on
// - option channels tag events with priority
// - disabled option channel ignores input entirely
// - option alarm on ON or OFF
// - readable conditioned ON/OFF state per channel
// - each channel selects one physical port
// - pulse mode triggers on OFF to ON
// - transition mode triggers on every change
module dic_top
    import dic_pkg::*;
#(
    parameter int MS_CYC = DIC_MS_CYC
)(
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset, high
    input wire dic_wb_req_s wb_i, // wishbone request
    output var dic_wb_rsp_s wb_o, // wishbone answer
    input wire logic [DIC_NP-1:0] port_i, // physical input pins
    output logic [DIC_NCH-1:0] state_o, // conditioned state
    output logic [DIC_NCH-1:0] trig_o, // trigger pulses
    output logic [DIC_NB-1:0] irig_o, // time-code level to clock
    output var dic_log_s [DIC_NCH-1:0] log_o, // event log strobes
    output logic irq_o // interrupt level
);

    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++)
        begin
            m[8*b +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction

    // base channels carry no priority, alarm or enable; options lose time-code
    function automatic dic_cfg_s clean_cfg(input logic [31:0] w, input logic opt);
        dic_cfg_s c;
        c = dic_cfg_s'(w);
        c.rsv1 = '0;
        c.rsv2 = '0;
        c.rsv3 = '0;
        if (opt && c.mode == DIC_TIME_CODE_MODE)
        begin
            c.mode = DIC_PULSE_MODE;
        end
        if (!opt)
        begin
            c.enable = 1'b1;
            c.alarm_on_off = 1'b0;
            c.priority_val = '0;
        end
        return c;
    endfunction

    dic_state_s r;
    dic_state_s next_r;

    logic req;
    logic [31:0] wmask;
    logic [2*DIC_NCH-1:0] set_ev;
    logic [2*DIC_NCH-1:0] clr_ev;
    logic sel_v;
    logic cand_v;
    logic chg_v;
    logic active_v;
    logic opt_v;
    logic [1:0] ch;

    always_comb
    begin
        next_r = r;
        req = wb_i.cyc & wb_i.stb;
        wmask = byte_mask(wb_i.sel);
        set_ev = '0;
        clr_ev = '0;
        sel_v = 1'b0;
        cand_v = 1'b0;
        chg_v = 1'b0;
        active_v = 1'b0;
        opt_v = 1'b0;
        ch = wb_i.adr[3:2];
        next_r.trig = '0;
        next_r.logv = '0;
        next_r.tick = 1'b0;
        next_r.sync1 = port_i;
        next_r.sync2 = r.sync1;
        if (r.msdiv == DIC_MSW'(MS_CYC - 1))
        begin
            next_r.msdiv = '0;
            next_r.tick = 1'b1;
        end
        else
        begin
            next_r.msdiv = r.msdiv + 1'b1;
        end

        for (int i = 0; i < DIC_NCH; i++)
        begin
            opt_v = (i >= DIC_NB);
            sel_v = r.sync2[r.cfg[i].port] ^ r.cfg[i].invert;
            active_v = !opt_v || r.cfg[i].enable;
            chg_v = 1'b0;
            // presence feeds the debouncer so a slow AC wave still reads ON
            cand_v = (r.cfg[i].mode == DIC_AC_MODE) ? (r.actmr[i] != '0) : sel_v;
            next_r.prev[i] = sel_v;
            if (!active_v)
            begin
                next_r.dbc[i] = '0;
                next_r.actmr[i] = '0;
            end
            else
            begin
                // window runs only in AC mode, so an edge seen in another mode
                // cannot make a freshly selected AC channel read ON
                if (r.cfg[i].mode != DIC_AC_MODE)
                begin
                    next_r.actmr[i] = '0;
                end
                else if (sel_v != r.prev[i])
                begin
                    next_r.actmr[i] = DIC_AC_WIN_MS;
                end
                else if (r.tick && r.actmr[i] != '0)
                begin
                    next_r.actmr[i] = r.actmr[i] - 1'b1;
                end
                if (cand_v == r.state[i])
                begin
                    next_r.dbc[i] = '0;
                end
                else if (r.dbc[i] >= r.deb[i])
                begin
                    next_r.dbc[i] = '0;
                    next_r.state[i] = cand_v;
                    chg_v = 1'b1;
                end
                else if (r.tick)
                begin
                    next_r.dbc[i] = r.dbc[i] + 1'b1;
                end
            end
            unique case (r.cfg[i].mode)
                DIC_PULSE_MODE:
                begin
                    next_r.trig[i] = chg_v & cand_v;
                    if (chg_v && cand_v)
                    begin
                        next_r.armed[i] = 1'b1;
                    end
                    else if (chg_v && r.armed[i])
                    begin
                        next_r.armed[i] = 1'b0;
                        next_r.cnt[i] = r.cnt[i] + 1'b1;
                    end
                end
                DIC_TRANSITION_COUNT_MODE:
                begin
                    next_r.trig[i] = chg_v;
                    next_r.armed[i] = 1'b0;
                    if (chg_v)
                    begin
                        next_r.cnt[i] = r.cnt[i] + 1'b1;
                    end
                end
                DIC_AC_MODE, DIC_TIME_CODE_MODE:
                begin
                    next_r.armed[i] = 1'b0;
                end
            endcase
            next_r.logv[i] = chg_v & r.cfg[i].event_log_select;
            set_ev[i] = chg_v;
            set_ev[DIC_NCH + i] = opt_v && chg_v && (cand_v == !r.cfg[i].alarm_on_off);
        end

        for (int b = 0; b < DIC_NB; b++)
        begin
            // the clock logic decodes frames; only the conditioned level goes there
            next_r.irig[b] = (r.cfg[b].mode == DIC_TIME_CODE_MODE) & next_r.state[b];
        end

        // registered ack: one wait state, then the write lands on the ack edge
        next_r.ack = 1'b0;
        if (req && !r.ack)
        begin
            next_r.ack = 1'b1;
            next_r.rdat = '0;
            if (wb_i.adr[7:6] == 2'b00)
            begin
                unique case ({wb_i.adr[7:4], 4'h0})
                    DIC_CFG_BASE: next_r.rdat = r.cfg[ch];
                    DIC_DEB_BASE: next_r.rdat = {22'h0, r.deb[ch]};
                    DIC_CNT_BASE: next_r.rdat = {16'h0, r.cnt[ch]};
                    default:
                    begin
                        unique case ({wb_i.adr[7:2], 2'b00})
                            DIC_STATE_OFS: next_r.rdat = {28'h0, r.state};
                            DIC_IST_OFS: next_r.rdat = {24'h0, r.irqst};
                            DIC_IEN_OFS: next_r.rdat = {24'h0, r.irqen};
                            default: next_r.rdat = '0;
                        endcase
                    end
                endcase
            end
        end
        if (req && r.ack && wb_i.we && wb_i.adr[7:6] == 2'b00)
        begin
            unique case ({wb_i.adr[7:4], 4'h0})
                DIC_CFG_BASE:
                begin
                    next_r.cfg[ch] = clean_cfg((r.cfg[ch] & ~wmask) | (wb_i.dat & wmask),
                        (32'(ch) >= DIC_NB));
                end
                DIC_DEB_BASE:
                begin
                    if (wb_i.sel[0])
                    begin
                        next_r.deb[ch][7:0] = wb_i.dat[7:0];
                    end
                    if (wb_i.sel[1])
                    begin
                        next_r.deb[ch][9:8] = wb_i.dat[9:8];
                    end
                    // anything past one second is held at one second
                    if (next_r.deb[ch] > DIC_DEB_MAX_MS)
                    begin
                        next_r.deb[ch] = DIC_DEB_MAX_MS;
                    end
                end
                DIC_CNT_BASE:
                begin
                end
                default:
                begin
                    if ({wb_i.adr[7:2], 2'b00} == DIC_ICLR_OFS && wb_i.sel[0])
                    begin
                        clr_ev = wb_i.dat[2*DIC_NCH-1:0];
                    end
                    if ({wb_i.adr[7:2], 2'b00} == DIC_IEN_OFS && wb_i.sel[0])
                    begin
                        next_r.irqen = wb_i.dat[2*DIC_NCH-1:0];
                    end
                end
            endcase
        end
        // a new event beats a clear in the same cycle
        next_r.irqst = (r.irqst & ~clr_ev) | set_ev;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            r <= '0;
            for (int i = 0; i < DIC_NCH; i++)
            begin
                r.cfg[i] <= dic_cfg_s'(DIC_CFG_RST);
                r.deb[i] <= DIC_DEB_RST;
            end
            r.irqen <= DIC_IEN_RST;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign wb_o.ack = r.ack;
    assign wb_o.dat = r.rdat;
    assign state_o = r.state;
    assign trig_o = r.trig;
    assign irig_o = r.irig;
    assign irq_o = |(r.irqst & r.irqen);

    generate
        for (genvar g = 0; g < DIC_NCH; g++)
        begin : g_log
            assign log_o[g].valid = r.logv[g];
            assign log_o[g].level = r.state[g];
            assign log_o[g].priority_val = r.cfg[g].priority_val;
        end
    endgenerate

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_pulse_rise_only: assert property (
        r.trig[0] && $past(r.cfg[0].mode) == DIC_PULSE_MODE |-> r.state[0] && !$past(r.state[0]))
        else $error("pulse trigger without rising state");
    a_trans_trig_each: assert property (
        $changed(r.state[1]) && $past(r.cfg[1].mode) == DIC_TRANSITION_COUNT_MODE |-> r.trig[1])
        else $error("transition trigger missing on change");
    a_pulse_count_fall: assert property (
        $past(r.cfg[0].mode) == DIC_PULSE_MODE && r.cnt[0] != $past(r.cnt[0])
        |-> $fell(r.state[0]) && r.cnt[0] == $past(r.cnt[0]) + 16'h1)
        else $error("pulse count not on completed pulse");
    a_trans_count_each: assert property (
        $past(r.cfg[1].mode) == DIC_TRANSITION_COUNT_MODE && $changed(r.state[1])
        |-> r.cnt[1] == $past(r.cnt[1]) + 16'h1)
        else $error("transition count not advanced");
    a_ac_needs_wave: assert property (
        $past(r.cfg[1].mode) == DIC_AC_MODE && $rose(r.state[1]) |-> $past(r.actmr[1]) != 6'h00)
        else $error("AC state on without signal");
    a_tc_no_count: assert property (
        $past(r.cfg[0].mode) == DIC_TIME_CODE_MODE |-> $stable(r.cnt[0]) && !r.trig[0])
        else $error("time-code channel counted");
    a_opt_no_tc: assert property (
        r.cfg[DIC_NB].mode != DIC_TIME_CODE_MODE)
        else $error("option channel in time-code mode");
    a_debounce_hold: assert property (
        $past(r.cfg[0].mode) != DIC_AC_MODE && $changed(r.state[0]) |-> $past(r.dbc[0]) >= $past(r.deb[0]))
        else $error("state accepted before debounce time");
    a_log_gated: assert property (
        r.logv[1] |-> $past(r.cfg[1].event_log_select) && $changed(r.state[1]))
        else $error("log entry while logging off");
    a_disabled_quiet: assert property (
        !$past(r.cfg[DIC_NCH-1].enable)
        |-> $stable(r.state[DIC_NCH-1]) && !r.logv[DIC_NCH-1] && !r.trig[DIC_NCH-1])
        else $error("disabled channel produced activity");
    a_alarm_select: assert property (
        $rose(r.irqst[DIC_NCH + DIC_NB]) |-> r.state[DIC_NB] == !$past(r.cfg[DIC_NB].alarm_on_off))
        else $error("alarm raised on wrong edge");
    a_bus_ack_once: assert property (
        r.ack |=> !r.ack)
        else $error("ack held longer than one cycle");

    c_pulse_counted: cover property (
        $past(r.cfg[0].mode) == DIC_PULSE_MODE && r.cnt[0] != $past(r.cnt[0]));
    c_trans_trig: cover property (
        r.trig[1] && $past(r.cfg[1].mode) == DIC_TRANSITION_COUNT_MODE);
    c_ac_on: cover property ($rose(r.state[1]) && $past(r.cfg[1].mode) == DIC_AC_MODE);
    c_irq_up: cover property ($rose(irq_o));

endmodule // dic_top
`default_nettype wire

//--- verification/dic_contacts.sv
`timescale 1ns/1ns
`default_nettype none
// contact model: steady levels, or a slow square wave where ac is asked
module dic_contacts
    import dic_pkg::*;
(
    input wire logic clk_i, // clock
    input wire logic [DIC_NP-1:0] lvl_i, // steady contact level
    input wire logic [DIC_NP-1:0] ac_i, // square wave instead of level
    output logic [DIC_NP-1:0] port_o = '0 // to the pins
);
    logic [3:0] div = 4'h0;
    // wave half period of 8 cycles keeps well inside the ac window
    always @(posedge clk_i)
    begin
        div <= div + 4'h1;
        port_o <= (ac_i & {DIC_NP{div[3]}}) | (lvl_i & ~ac_i);
    end
endmodule // dic_contacts
`default_nettype wire

//--- verification/digital_input_conditioner_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module digital_input_conditioner_tb_top
    import dic_pkg::*;
;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    dic_wb_req_s wb_i = '0;
    dic_wb_rsp_s wb_o;
    logic [DIC_NP-1:0] lvl = '0;
    logic [DIC_NP-1:0] ac = '0;
    logic [DIC_NP-1:0] port;
    logic [DIC_NCH-1:0] state_o;
    logic [DIC_NCH-1:0] trig_o;
    logic [DIC_NB-1:0] irig_o;
    dic_log_s [DIC_NCH-1:0] log_o;
    logic irq_o;
    logic [31:0] tc [DIC_NCH] = '{default: '0};
    logic [31:0] lc [DIC_NCH] = '{default: '0};
    logic [7:0] lp = 8'h00;
    int err_count = 0;
    int total_checks = 0;
    int cyc = 0;
    int n;

    always #50 clk_i = ~clk_i;

    dic_contacts i_dic_contacts (.clk_i(clk_i), .lvl_i(lvl), .ac_i(ac), .port_o(port));
    // short tick so debounce and ac window stay within a quick run
    dic_top #(.MS_CYC(10)) i_dic_top (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
        .wb_o(wb_o), .port_i(port), .state_o(state_o), .trig_o(trig_o),
        .irig_o(irig_o), .log_o(log_o), .irq_o(irq_o));

    always @(posedge clk_i)
    begin
        for (int i = 0; i < DIC_NCH; i++)
        begin
            tc[i] <= tc[i] + {31'h0, trig_o[i]};
            lc[i] <= lc[i] + {31'h0, log_o[i].valid};
        end
        if (log_o[2].valid === 1'b1)
            lp <= log_o[2].priority_val;
        cyc++;
        if (cyc == 30000)
        begin
            err_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (err_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_i);
        wb_i <= '{1'b1, 1'b1, w, a, 4'hf, d};
        @(posedge clk_i);
        while (wb_o.ack !== 1'b1)
            @(posedge clk_i);
        q = wb_o.dat;
        wb_i.cyc <= 1'b0;
        wb_i.stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    // bounded wait for a channel state; returns cycles taken
    task automatic wst(input int ch, input logic v, input int lim, output int k);
        k = 0;
        while (state_o[ch] !== v && k < lim)
        begin
            @(posedge clk_i);
            #1;
            k++;
        end
        chk({31'h0, state_o[ch]}, {31'h0, v});
    endtask

    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(8'h00, 32'h10);
        rc(8'h08, 32'h10);
        rc(8'h10, 32'h0);
        rc(8'h34, 32'h0);
        rc(8'h3c, 32'h0);
        wr(8'h40, 32'hff);
        rc(8'h40, 32'h0);
        wr(8'h04, 32'h119);
        wr(8'h08, 32'h210);
        wr(8'h0c, 32'h310);
        @(posedge clk_i) lvl[0] <= 1'b1;
        wst(0, 1'b1, 20, n);
        rc(8'h20, 32'h0);
        @(posedge clk_i) lvl[0] <= 1'b0;
        wst(0, 1'b0, 20, n);
        rc(8'h20, 32'h1);
        chk(tc[0], 32'h1);
        rc(8'h34, 32'h1);
        wr(8'h38, 32'hff);
        @(posedge clk_i) lvl[1] <= 1'b1;
        wst(1, 1'b1, 20, n);
        @(posedge clk_i) lvl[1] <= 1'b0;
        wst(1, 1'b0, 20, n);
        rc(8'h24, 32'h2);
        chk(tc[1], 32'h2);
        chk(lc[1], 32'h2);
        chk(lc[0], 32'h0);
        wr(8'h00, 32'h14);
        wst(0, 1'b1, 20, n);
        wr(8'h00, 32'h10);
        wst(0, 1'b0, 20, n);
        wr(8'h10, 32'h7ff);
        rc(8'h10, 32'h3e8);
        wr(8'h10, 32'h5);
        @(posedge clk_i) lvl[0] <= 1'b1;
        repeat (20) @(posedge clk_i);
        lvl[0] <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk({31'h0, state_o[0]}, 32'h0);
        @(posedge clk_i) lvl[0] <= 1'b1;
        wst(0, 1'b1, 100, n);
        chk({31'h0, (n >= 40 && n <= 60)}, 32'h1);
        wr(8'h10, 32'h0);
        @(posedge clk_i) lvl[0] <= 1'b0;
        wst(0, 1'b0, 100, n);
        wr(8'h00, 32'h13);
        @(posedge clk_i) lvl[0] <= 1'b1;
        wst(0, 1'b1, 20, n);
        chk({30'h0, irig_o}, 32'h1);
        @(posedge clk_i) lvl[0] <= 1'b0;
        wst(0, 1'b0, 20, n);
        chk({30'h0, irig_o}, 32'h0);
        wr(8'h08, 32'h213);
        rc(8'h08, 32'h210);
        wr(8'h38, 32'hff);
        wr(8'h3c, 32'hcc);
        wr(8'h08, 32'h005a0238);
        @(posedge clk_i) lvl[2] <= 1'b1;
        wst(2, 1'b1, 20, n);
        rc(8'h34, 32'h04);
        chk({24'h0, lp}, 32'h5a);
        chk({31'h0, irq_o}, 32'h1);
        wr(8'h38, 32'h04);
        rc(8'h34, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        @(posedge clk_i) lvl[2] <= 1'b0;
        wst(2, 1'b0, 20, n);
        rc(8'h34, 32'h44);
        @(posedge clk_i) lvl[3] <= 1'b1;
        wst(3, 1'b1, 20, n);
        rc(8'h34, 32'hcc);
        wr(8'h38, 32'hff);
        wr(8'h0c, 32'h300);
        @(posedge clk_i) lvl[3] <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk({31'h0, state_o[3]}, 32'h1);
        rc(8'h30, 32'h8);
        rc(8'h34, 32'h0);
        chk({31'h0, irq_o}, 32'h0);
        wr(8'h04, 32'h512);
        @(posedge clk_i) ac[5] <= 1'b1;
        wst(1, 1'b1, 100, n);
        repeat (100) @(posedge clk_i);
        chk({31'h0, state_o[1]}, 32'h1);
        ac[5] <= 1'b0;
        wst(1, 1'b0, 700, n);
        chk({31'h0, (n >= 470 && n <= 520)}, 32'h1);
        chk(tc[1], 32'h2);
        chk(tc[2], 32'h1);
        finish_test();
    end
endmodule // digital_input_conditioner_tb_top
`default_nettype wire
